// ### design/ref_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "ref_switch_consts.svh"
module ref_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // divided reference
  input wire logic div_pulse,
  // presence verdict
  output logic present
);
  logic [11:0] gap_reg;
  localparam logic [11:0] LOSS_LIMIT = 12'(`REF_LOSS_CYCLES);

  // the limit must exceed the slowest divided period in use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg <= 12'h000;
      present <= 1'b0;
    end else if (div_pulse) begin
      gap_reg <= 12'h000;
      present <= 1'b1;
    end else if (gap_reg >= LOSS_LIMIT - 12'h001) begin
      present <= 1'b0;
    end else begin
      gap_reg <= gap_reg + 12'h001;
    end
  end

  a_loss_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
    (!div_pulse && gap_reg == LOSS_LIMIT - 12'h001) |=> !present)
    else $error("reference not declared lost at limit");
  a_pulse_present: assert property (@(posedge aclk) disable iff (!aresetn)
    div_pulse |=> present && gap_reg == 12'h000)
    else $error("divided pulse did not mark presence");
endmodule : ref_monitor
`default_nettype wire

// ### design/ref_prediv.sv
`timescale 1ns/100ps
`default_nettype none
`include "ref_switch_consts.svh"
module ref_prediv
  import ref_switch_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reference pin and ratio
  input wire logic ref_pin,
  input wire div_ratio_t div_value,
  // one pulse per divided period
  output logic div_pulse
);
  logic s1_reg, s2_reg, s3_reg, level_reg;
  div_ratio_t cnt_reg;
  logic rise, last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= ref_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign rise = (s2_reg == s3_reg) && s3_reg && !level_reg;
  // a ratio of zero is taken as one so the divider never stalls
  assign last = (div_value <= 10'h001) || (cnt_reg >= div_value - 10'h001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 10'h000;
      div_pulse <= 1'b0;
    end else begin
      div_pulse <= rise && last;
      if (rise) begin
        cnt_reg <= last ? 10'h000 : cnt_reg + 10'h001;
      end
    end
  end

  a_div_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (rise && !last) |=> !div_pulse)
    else $error("divided pulse before ratio reached");
endmodule : ref_prediv
`default_nettype wire

// ### design/ref_switch_consts.svh
// What this block does
// - each reference has its own divider, integer ratio 1 through 1023
// - presence is judged on divided references and drives switchover control
// - one reference present is used; with two, one active, other backup
// - active reference failing moves to an available backup automatically
// - switchover fires when primary disappears and secondary is present
// - nonrevertive stays on secondary; returns only if secondary disappears
// - revertive returns to primary as soon as primary is detected again
// - a configuration bit picks revertive or nonrevertive behaviour
// - manual selection by register bit or by external select pin
// - no reference present enters holdover with charge pump tristated
// - holdover lasts until a reference returns, then loop resynchronises
// - misc bit 6 forces charge pump to mid-supply during holdover
// - differential receiver off when not selected or loop powered down
// - single-ended buffer off on loop power-down, own bit, or differential
// - secondary divider copies primary unless misc bit 7 is set
`ifndef REF_SWITCH_CONSTS_SVH
`define REF_SWITCH_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_DIV_PRI 10'h010
`define IDX_DIV_SEC 10'h012
`define IDX_INPUT_CFG 10'h01a
`define IDX_MISC 10'h01c
`define IDX_STATUS 10'h020

`define CFG_LOOP_PD_BIT 0
`define CFG_PRI_SE_PD_BIT 1
`define CFG_SEC_SE_PD_BIT 2
`define CFG_PRI_CMOS_BIT 5
`define CFG_SEC_CMOS_BIT 6

`define MISC_REVERT_BIT 0
`define MISC_MANUAL_BIT 1
`define MISC_MAN_SEL_BIT 2
`define MISC_PIN_SEL_BIT 3
`define MISC_CP_MID_BIT 6
`define MISC_INDEP_DIV_BIT 7

`define ST_ACTIVE_SEC_BIT 0
`define ST_PRI_PRESENT_BIT 1
`define ST_SEC_PRESENT_BIT 2
`define ST_HOLDOVER_BIT 3
`define ST_HOLD_ENTERED_BIT 4
`define ST_SWITCHED_BIT 5

`define DIV_RESET 10'h001
`define CFG_RESET 8'h00
`define MISC_RESET 8'h00

`define CLK_MHZ 40
`define REF_LOSS_US 100
`define REF_LOSS_CYCLES (`REF_LOSS_US * `CLK_MHZ)

`endif

// ### design/ref_switch_pkg.sv
package ref_switch_pkg;
  typedef enum logic [1:0] {
    ST_PRIMARY = 2'b00,
    ST_SECONDARY = 2'b01,
    ST_HOLDOVER = 2'b10
  } ref_state_t;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
  typedef logic [9:0] div_ratio_t;
endpackage : ref_switch_pkg

// ### design/ref_switchover.sv
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "ref_switch_consts.svh"
module ref_switchover
  import ref_switch_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reference pins
  input wire logic primary_reference_input,
  input wire logic secondary_reference_input,
  input wire logic ref_select_pin,
  // loop control
  output logic active_secondary,
  output logic holdover_active,
  output logic cp_tristate,
  output logic cp_midsupply,
  output logic input_loop_resync,
  // receiver power-down
  output logic pri_diff_rx_pd,
  output logic sec_diff_rx_pd,
  output logic pri_se_buf_pd,
  output logic sec_se_buf_pd
);
  div_ratio_t div_pri_reg, div_sec_reg, div_sec_eff;
  logic [7:0] cfg_reg, misc_reg;
  logic hold_entered_reg, switched_reg;
  logic [11:2] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_ok, wr_ok;
  logic pri_pulse, sec_pulse, pri_present, sec_present;
  logic sel1_reg, sel2_reg, sel3_reg, sel_level_reg;
  ref_state_t state_reg, state_next;
  logic manual, want_sec, revert;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // ---------------- bus slave ----------------
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ok = (awaddr_reg == `IDX_DIV_PRI) || (awaddr_reg == `IDX_DIV_SEC) ||
                 (awaddr_reg == `IDX_INPUT_CFG) || (awaddr_reg == `IDX_MISC) ||
                 (awaddr_reg == `IDX_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_reg <= 10'h000;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_reg <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[11:2])
      `IDX_DIV_PRI: rd_data = {22'h0, div_pri_reg};
      `IDX_DIV_SEC: rd_data = {22'h0, div_sec_reg};
      `IDX_INPUT_CFG: rd_data = {24'h0, cfg_reg};
      `IDX_MISC: rd_data = {24'h0, misc_reg};
      `IDX_STATUS: rd_data = {26'h0, switched_reg, hold_entered_reg, holdover_active,
                              sec_present, pri_present, active_secondary};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_pri_reg <= `DIV_RESET;
      div_sec_reg <= `DIV_RESET;
      cfg_reg <= `CFG_RESET;
      misc_reg <= `MISC_RESET;
    end else if (wr_en) begin
      unique case (awaddr_reg)
        `IDX_DIV_PRI: div_pri_reg <= 10'(wmerge({22'h0, div_pri_reg}, wdata_reg, wstrb_reg));
        `IDX_DIV_SEC: div_sec_reg <= 10'(wmerge({22'h0, div_sec_reg}, wdata_reg, wstrb_reg));
        `IDX_INPUT_CFG: cfg_reg <= 8'(wmerge({24'h0, cfg_reg}, wdata_reg, wstrb_reg));
        `IDX_MISC: misc_reg <= 8'(wmerge({24'h0, misc_reg}, wdata_reg, wstrb_reg));
        default: ;
      endcase
    end
  end

  // ---------------- dividers and monitors ----------------
  assign div_sec_eff = misc_reg[`MISC_INDEP_DIV_BIT] ? div_sec_reg : div_pri_reg;

  ref_prediv u_pri_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_pin(primary_reference_input),
    .div_value(div_pri_reg),
    .div_pulse(pri_pulse)
  );
  ref_prediv u_sec_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_pin(secondary_reference_input),
    .div_value(div_sec_eff),
    .div_pulse(sec_pulse)
  );
  ref_monitor u_pri_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .div_pulse(pri_pulse),
    .present(pri_present)
  );
  ref_monitor u_sec_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .div_pulse(sec_pulse),
    .present(sec_present)
  );

  // select pin is asynchronous; act only once two late stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel1_reg <= 1'b0;
      sel2_reg <= 1'b0;
      sel3_reg <= 1'b0;
      sel_level_reg <= 1'b0;
    end else begin
      sel1_reg <= ref_select_pin;
      sel2_reg <= sel1_reg;
      sel3_reg <= sel2_reg;
      if (sel2_reg == sel3_reg) begin
        sel_level_reg <= sel3_reg;
      end
    end
  end

  // ---------------- switchover control ----------------
  assign manual = misc_reg[`MISC_MANUAL_BIT];
  assign revert = misc_reg[`MISC_REVERT_BIT];
  assign want_sec = misc_reg[`MISC_PIN_SEL_BIT] ? sel_level_reg
                                                 : misc_reg[`MISC_MAN_SEL_BIT];

  always_comb begin
    state_next = state_reg;
    if (!pri_present && !sec_present) begin
      state_next = ST_HOLDOVER;
    end else if (manual) begin
      // a manual choice of a missing reference holds over rather than drift
      if (want_sec) begin
        state_next = sec_present ? ST_SECONDARY : ST_HOLDOVER;
      end else begin
        state_next = pri_present ? ST_PRIMARY : ST_HOLDOVER;
      end
    end else begin
      unique case (state_reg)
        ST_PRIMARY: if (!pri_present) state_next = ST_SECONDARY;
        ST_SECONDARY: begin
          // revertive mode returns as soon as the primary is back
          if (!sec_present || (revert && pri_present)) begin
            state_next = ST_PRIMARY;
          end
        end
        ST_HOLDOVER: state_next = pri_present ? ST_PRIMARY : ST_SECONDARY;
        default: state_next = ST_HOLDOVER;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_HOLDOVER;
      active_secondary <= 1'b0;
      holdover_active <= 1'b1;
      cp_tristate <= 1'b1;
      cp_midsupply <= 1'b0;
      input_loop_resync <= 1'b0;
    end else begin
      state_reg <= state_next;
      active_secondary <= (state_next == ST_SECONDARY);
      holdover_active <= (state_next == ST_HOLDOVER);
      cp_midsupply <= (state_next == ST_HOLDOVER) && misc_reg[`MISC_CP_MID_BIT];
      cp_tristate <= (state_next == ST_HOLDOVER) && !misc_reg[`MISC_CP_MID_BIT];
      input_loop_resync <= (state_next != state_reg) && (state_next != ST_HOLDOVER);
    end
  end

  // sticky events clear on writing one; a new event in that cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_entered_reg <= 1'b0;
      switched_reg <= 1'b0;
    end else begin
      hold_entered_reg <= (state_next == ST_HOLDOVER && state_reg != ST_HOLDOVER) ||
        (hold_entered_reg && !(wr_en && awaddr_reg == `IDX_STATUS && wstrb_reg[0] &&
        wdata_reg[`ST_HOLD_ENTERED_BIT]));
      switched_reg <= (state_next != state_reg && state_reg != ST_HOLDOVER &&
        state_next != ST_HOLDOVER) ||
        (switched_reg && !(wr_en && awaddr_reg == `IDX_STATUS && wstrb_reg[0] &&
        wdata_reg[`ST_SWITCHED_BIT]));
    end
  end

  // ---------------- receiver power-down ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_diff_rx_pd <= 1'b0;
      sec_diff_rx_pd <= 1'b0;
      pri_se_buf_pd <= 1'b1;
      sec_se_buf_pd <= 1'b1;
    end else begin
      pri_diff_rx_pd <= cfg_reg[`CFG_PRI_CMOS_BIT] || cfg_reg[`CFG_LOOP_PD_BIT];
      sec_diff_rx_pd <= cfg_reg[`CFG_SEC_CMOS_BIT] || cfg_reg[`CFG_LOOP_PD_BIT];
      pri_se_buf_pd <= cfg_reg[`CFG_LOOP_PD_BIT] || cfg_reg[`CFG_PRI_SE_PD_BIT] ||
                       !cfg_reg[`CFG_PRI_CMOS_BIT];
      sec_se_buf_pd <= cfg_reg[`CFG_LOOP_PD_BIT] || cfg_reg[`CFG_SEC_SE_PD_BIT] ||
                       !cfg_reg[`CFG_SEC_CMOS_BIT];
    end
  end

  // ---------------- checks ----------------
  a_single_ref_used: assert property (@(posedge aclk) disable iff (!aresetn)
    (!manual && pri_present && !sec_present) |=> !active_secondary && !holdover_active)
    else $error("lone primary not made active");
  a_fail_to_backup: assert property (@(posedge aclk) disable iff (!aresetn)
    (!manual && state_reg == ST_PRIMARY && !pri_present && sec_present)
    |=> active_secondary ##0 input_loop_resync)
    else $error("no switchover to secondary");
  a_nonrevert_stays: assert property (@(posedge aclk) disable iff (!aresetn)
    (!manual && !revert && state_reg == ST_SECONDARY && sec_present) |=> active_secondary)
    else $error("left secondary in nonrevertive mode");
  a_revert_primary: assert property (@(posedge aclk) disable iff (!aresetn)
    (!manual && revert && state_reg == ST_SECONDARY && pri_present)
    |=> !active_secondary && !holdover_active)
    else $error("no return to primary in revertive mode");
  a_holdover_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pri_present && !sec_present) |=> holdover_active && (cp_tristate || cp_midsupply))
    else $error("holdover not entered");
  a_holdover_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    (!manual && state_reg == ST_HOLDOVER && (pri_present || sec_present))
    |=> !holdover_active && input_loop_resync ##1 !input_loop_resync)
    else $error("holdover exit without resync");
  a_cp_midsupply: assert property (@(posedge aclk) disable iff (!aresetn)
    holdover_active |-> (cp_tristate ^ cp_midsupply) &&
      (cp_midsupply == $past(misc_reg[`MISC_CP_MID_BIT])))
    else $error("charge pump state wrong in holdover");
  a_diff_rx_pd: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(cfg_reg[`CFG_LOOP_PD_BIT]) |-> pri_diff_rx_pd && sec_diff_rx_pd &&
      pri_se_buf_pd && sec_se_buf_pd)
    else $error("receivers alive during loop power-down");
  a_manual_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (manual && misc_reg[`MISC_PIN_SEL_BIT] && sel_level_reg && sec_present)
    |=> active_secondary)
    else $error("select pin ignored");
endmodule : ref_switchover
`default_nettype wire

// ### test/ref_clock_source.sv
`timescale 1ns/100ps
`default_nettype none
module ref_clock_source (
  // control from the bench
  input wire logic run,
  input wire logic [7:0] half_cycles,
  // reference pin
  output logic ref_out
);
  initial ref_out = 1'b0;
  // the odd 7 ns keeps edges drifting against aclk, so no fixed phase hides a sampling slip
  always begin
    if (run) begin
      #(half_cycles * 25 + 7);
      ref_out = ~ref_out;
    end else begin
      // a lost reference stands still low, as a dead source would
      ref_out = 1'b0;
      #25;
    end
  end
endmodule : ref_clock_source
`default_nettype wire

// ### test/test_ref_switchover.sv
`timescale 1ns/100ps
`default_nettype none
`include "ref_switch_consts.svh"
module test_ref_switchover
  import ref_switch_pkg::*;
  ;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} rd_exp_t;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic primary_reference_input, secondary_reference_input, ref_select_pin;
  logic active_secondary, holdover_active, cp_tristate, cp_midsupply, input_loop_resync;
  logic pri_diff_rx_pd, sec_diff_rx_pd, pri_se_buf_pd, sec_se_buf_pd;
  logic run_p, run_s;
  logic [7:0] hp, hs;
  logic [31:0] c;
  rd_exp_t rq[$];
  rd_exp_t e_r;
  logic [1:0] bq[$];
  int n_fail, comparisons, n_resync, r0, n;

  ref_switchover i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .primary_reference_input, .secondary_reference_input,
    .ref_select_pin, .active_secondary, .holdover_active, .cp_tristate, .cp_midsupply,
    .input_loop_resync, .pri_diff_rx_pd, .sec_diff_rx_pd, .pri_se_buf_pd, .sec_se_buf_pd);
  ref_clock_source i_src_p (.run(run_p), .half_cycles(hp), .ref_out(primary_reference_input));
  ref_clock_source i_src_s (.run(run_s), .half_cycles(hs), .ref_out(secondary_reference_input));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check_val

  task automatic chk_state(input logic [3:0] e);
    check_val("loop state", {28'h0, e},
      {28'h0, active_secondary, holdover_active, cp_tristate, cp_midsupply});
  endtask : chk_state

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  task automatic rd(input logic [9:0] idx, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    rq.push_back('{d, m, r});
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
  endtask : rd

  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] r);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask : wr

  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask : done_test

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // scoreboard side: every response that appears takes the oldest note
  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      e_r = rq.pop_front();
      check_val("read data", e_r.data, s_axi_rdata & e_r.mask);
      check_val("read resp", {30'h0, e_r.resp}, {30'h0, s_axi_rresp});
    end
    if (aresetn && s_axi_bvalid && s_axi_bready) begin
      check_val("write resp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
    end
    if (aresetn && input_loop_resync) begin
      n_resync++;
    end
  end

  initial begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    $display("unexpected run length: expected finish, seen watchdog expiry");
    end_of_test();
  end

  initial begin
    void'($urandom(47));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ref_select_pin, run_p, run_s} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    // both ready lines held up: the bench always accepts a response at once
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    hp = 8'(4 + $urandom % 8);
    hs = 8'(4 + $urandom % 8);
    {n_fail, comparisons, n_resync} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_state(4'b0110);
    rd(`IDX_DIV_PRI, 32'h1, 32'hffffffff, RESP_OKAY);
    rd(`IDX_DIV_SEC, 32'h1, 32'hffffffff, RESP_OKAY);
    rd(`IDX_INPUT_CFG, 32'h0, 32'hffffffff, RESP_OKAY);
    rd(`IDX_MISC, 32'h0, 32'hffffffff, RESP_OKAY);
    rd(`IDX_STATUS, 32'h8, 32'h0f, RESP_OKAY);
    rd(10'h001, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(10'h001, 32'hffffffff, RESP_SLVERR);
    rd(`IDX_MISC, 32'h0, 32'hffffffff, RESP_OKAY);
    wr(`IDX_MISC, 32'h40, RESP_OKAY);
    cyc(2);
    chk_state(4'b0101);
    wr(`IDX_MISC, 32'h0, RESP_OKAY);
    done_test("reset and holdover output");
    wr(`IDX_DIV_PRI, 32'h7ff, RESP_OKAY);
    rd(`IDX_DIV_PRI, 32'h3ff, 32'hffffffff, RESP_OKAY);
    wr(`IDX_DIV_PRI, 32'h1, RESP_OKAY);
    // primary first, so leaving holdover has one clear choice
    run_p <= 1'b1;
    cyc(400);
    run_s <= 1'b1;
    cyc(400);
    chk_state(4'b0000);
    rd(`IDX_STATUS, 32'h6, 32'h7, RESP_OKAY);
    // live pins, but divided periods far past the loss limit
    wr(`IDX_DIV_PRI, 32'h3ff, RESP_OKAY);
    n = 0;
    while (!holdover_active && n < 12000) begin
      @(posedge aclk);
      n++;
    end
    chk_state(4'b0110);
    run_p <= 1'b0;
    wr(`IDX_DIV_PRI, 32'h1, RESP_OKAY);
    wr(`IDX_MISC, 32'h80, RESP_OKAY);
    cyc(400);
    chk_state(4'b1000);
    wr(`IDX_MISC, 32'h0, RESP_OKAY);
    run_p <= 1'b1;
    cyc(400);
    chk_state(4'b1000);
    done_test("divided presence");
    run_s <= 1'b0;
    cyc(4400);
    chk_state(4'b0000);
    run_s <= 1'b1;
    cyc(400);
    run_p <= 1'b0;
    cyc(4400);
    chk_state(4'b1000);
    rd(`IDX_STATUS, 32'h25, 32'h27, RESP_OKAY);
    wr(`IDX_STATUS, 32'h20, RESP_OKAY);
    rd(`IDX_STATUS, 32'h0, 32'h20, RESP_OKAY);
    run_p <= 1'b1;
    cyc(400);
    chk_state(4'b1000);
    wr(`IDX_MISC, 32'h1, RESP_OKAY);
    cyc(4);
    chk_state(4'b0000);
    done_test("automatic switchover");
    wr(`IDX_MISC, 32'h06, RESP_OKAY);
    cyc(4);
    chk_state(4'b1000);
    // pin mode must ignore the register choice of secondary
    wr(`IDX_MISC, 32'h0e, RESP_OKAY);
    cyc(6);
    chk_state(4'b0000);
    ref_select_pin <= 1'b1;
    cyc(6);
    chk_state(4'b1000);
    wr(`IDX_MISC, 32'h0, RESP_OKAY);
    done_test("manual selection");
    r0 = n_resync;
    run_p <= 1'b0;
    run_s <= 1'b0;
    cyc(4400);
    chk_state(4'b0110);
    rd(`IDX_STATUS, 32'h18, 32'h1f, RESP_OKAY);
    run_s <= 1'b1;
    cyc(400);
    chk_state(4'b1000);
    check_val("resync pulses", 32'(r0 + 1), 32'(n_resync));
    done_test("holdover exit");
    repeat (8) begin
      c = $urandom & 32'h67;
      wr(`IDX_INPUT_CFG, c, RESP_OKAY);
      cyc(2);
      check_val("power-down", {28'h0, c[0] | c[5], c[0] | c[6], c[0] | c[1] | ~c[5],
        c[0] | c[2] | ~c[6]}, {28'h0, pri_diff_rx_pd, sec_diff_rx_pd, pri_se_buf_pd,
        sec_se_buf_pd});
    end
    done_test("receiver power-down");
    end_of_test();
  end
endmodule : test_ref_switchover
`default_nettype wire
